// [hdl/pmx_pkg.sv]
`default_nettype none
package pmx_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFF_SEL_HIGH = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SEL_MID  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_SEL_LOW  = 4'h8;

  // Implemented field bits; every other bit reads as zero and ignores writes.
  localparam logic [DATA_W-1:0] HIGH_MASK = 16'hFE0F;
  localparam logic [DATA_W-1:0] MID_MASK  = 16'h00FF;
  localparam logic [DATA_W-1:0] LOW_MASK  = 16'hFFFC;

  localparam logic [DATA_W-1:0] HIGH_RST = 16'h0000;
  localparam logic [DATA_W-1:0] MID_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] LOW_RST  = 16'h0000;
  // Top mode bits of lines 15 to 12 and 10 that come up set in debug mode.
  localparam logic [DATA_W-1:0] HIGH_DBG_SET = 16'hF400;

  localparam int unsigned MID_LAST_LINE  = 3;
  localparam int unsigned LOW_FIRST_LINE = 9;
  localparam int unsigned LOW_BIT_SHIFT  = 16;

  localparam logic [2:0] MD_PORT = 3'h0;
  localparam logic [2:0] MD_SEL1 = 3'h1;
  localparam logic [2:0] MD_SEL2 = 3'h2;
  localparam logic [2:0] MD_SEL3 = 3'h3;
  localparam logic [2:0] MD_SEL4 = 3'h4;
  localparam logic [2:0] MD_SEL5 = 3'h5;
  localparam logic [2:0] MD_SEL6 = 3'h6;

  // Signals driven by peripherals toward the pins; each _oe is active high.
  typedef struct packed {
    logic serial2_transmit;
    logic serial3_transmit;
    logic serial2_clock_out;
    logic serial2_clock_oe;
    logic serial3_clock_out;
    logic serial3_clock_oe;
    logic motor_pwm_out;
    logic motor_pwm_oe;
    logic system_clock_out;
    logic bus_release_ack;
    logic read_strobe;
    logic low_byte_write_strobe;
    logic chip_select0;
    logic break_trigger_out;
    logic jtag_tdo;
  } pmx_drive_t;

  // Pin levels handed to peripherals; zero while no line selects them.
  typedef struct packed {
    logic out_disable_in0;
    logic out_disable_in1;
    logic out_disable_in4;
    logic out_disable_in5;
    logic out_disable_in6;
    logic serial2_receive;
    logic serial3_receive;
    logic serial2_clock_in;
    logic serial3_clock_in;
    logic ext_interrupt0;
    logic ext_interrupt3;
    logic motor_pwm_in;
    logic timer_ext_clock_d;
    logic converter_ext_trigger;
    logic bus_request_in;
    logic jtag_trst;
    logic jtag_tms;
    logic jtag_tdi;
    logic jtag_tck;
  } pmx_sense_t;
endpackage
`default_nettype wire

// [hdl/pmx_porta_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module pmx_porta_mux (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_reset,
  input  wire logic [pmx_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [pmx_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [pmx_pkg::DATA_W-1:0]    o_rdata,
  input  wire logic                          i_debug_mode_n,
  input  wire logic [15:0]                   i_pin_in,
  output logic      [15:0]                   o_pin_out,
  output logic      [15:0]                   o_pin_oe_n,
  input  wire logic [15:0]                   i_gpio_out,
  input  wire logic [15:0]                   i_gpio_dir,
  output logic      [15:0]                   o_gpio_in,
  input  wire pmx_pkg::pmx_drive_t           i_periph,
  output pmx_pkg::pmx_sense_t                o_periph
);

  logic [15:0]               pin_meta_ff;
  logic [15:0]               pin_sync_ff;
  logic                      dbg_meta_ff;
  logic                      dbg_sync_ff;
  logic [15:0]               sel_high_ff;
  logic [15:0]               sel_mid_ff;
  logic [15:0]               sel_low_ff;
  logic [15:0]               nxt_sel_high;
  logic [15:0]               nxt_sel_mid;
  logic [15:0]               nxt_sel_low;
  logic [15:0]               rdata_ff;
  logic [15:0]               nxt_rdata;
  logic [15:0]               pin_out_ff;
  logic [15:0]               nxt_pin_out;
  logic [15:0]               pin_oe_n_ff;
  logic [15:0]               nxt_pin_oe_n;
  logic [15:0]               gpio_in_ff;
  logic [15:0]               nxt_gpio_in;
  pmx_pkg::pmx_sense_t       sense_ff;
  pmx_pkg::pmx_sense_t       nxt_sense;
  logic [2:0]                mode [16];

  // Gathers the three-bit field of one line from the split registers.
  function automatic logic [2:0] line_mode(input logic [15:0] hi, input logic [15:0] mid,
                                           input logic [15:0] lo, input int unsigned p);
    if (p <= pmx_pkg::MID_LAST_LINE) begin
      return {hi[p], mid[2*p+1], mid[2*p]};
    end else if (p >= pmx_pkg::LOW_FIRST_LINE) begin
      return {hi[p], lo[2*p-pmx_pkg::LOW_BIT_SHIFT+1], lo[2*p-pmx_pkg::LOW_BIT_SHIFT]};
    end
    return pmx_pkg::MD_PORT;
  endfunction

  // Pins are asynchronous to the core, so they pass two stages before use.
  always_ff @(posedge i_core_clk) begin
    pin_meta_ff <= i_pin_in;
    pin_sync_ff <= pin_meta_ff;
    dbg_meta_ff <= i_debug_mode_n;
    dbg_sync_ff <= dbg_meta_ff;
  end

  always_comb begin : reg_next
    nxt_sel_high = sel_high_ff;
    nxt_sel_mid  = sel_mid_ff;
    nxt_sel_low  = sel_low_ff;
    nxt_rdata    = '0;
    if (i_reset) begin
      nxt_sel_high = pmx_pkg::HIGH_RST;
      nxt_sel_mid  = pmx_pkg::MID_RST;
      nxt_sel_low  = pmx_pkg::LOW_RST;
      // The strap is sampled through the synchroniser, so reset must span three edges after the strap changes.
      if (!dbg_sync_ff) begin
        nxt_sel_high = pmx_pkg::HIGH_RST | pmx_pkg::HIGH_DBG_SET;
      end
    end else begin
      if (i_wr) begin
        unique case (i_addr)
          pmx_pkg::OFF_SEL_HIGH: nxt_sel_high = i_wdata & pmx_pkg::HIGH_MASK;
          pmx_pkg::OFF_SEL_MID:  nxt_sel_mid  = i_wdata & pmx_pkg::MID_MASK;
          pmx_pkg::OFF_SEL_LOW:  nxt_sel_low  = i_wdata & pmx_pkg::LOW_MASK;
          default: ;
        endcase
      end
      if (i_rd) begin
        unique case (i_addr)
          pmx_pkg::OFF_SEL_HIGH: nxt_rdata = sel_high_ff;
          pmx_pkg::OFF_SEL_MID:  nxt_rdata = sel_mid_ff;
          pmx_pkg::OFF_SEL_LOW:  nxt_rdata = sel_low_ff;
          default:               nxt_rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    sel_high_ff <= nxt_sel_high;
    sel_mid_ff  <= nxt_sel_mid;
    sel_low_ff  <= nxt_sel_low;
    rdata_ff    <= nxt_rdata;
  end

  always_comb begin : mode_decode
    for (int unsigned p = 0; p < 16; p++) begin
      mode[p] = line_mode(sel_high_ff, sel_mid_ff, sel_low_ff, p);
    end
  end

  // Codes that select nothing fall to the default arm and keep the port path.
  always_comb begin : pin_route
    nxt_pin_out  = i_gpio_out;
    nxt_pin_oe_n = ~i_gpio_dir;
    nxt_gpio_in  = pin_sync_ff;
    nxt_sense    = '0;
    unique case (mode[0])
      pmx_pkg::MD_SEL5: begin nxt_pin_oe_n[0] = 1'b1; nxt_sense.out_disable_in0 = pin_sync_ff[0]; end
      pmx_pkg::MD_SEL6: begin nxt_pin_oe_n[0] = 1'b1; nxt_sense.serial2_receive = pin_sync_ff[0]; end
      default: ;
    endcase
    unique case (mode[1])
      pmx_pkg::MD_SEL5: begin nxt_pin_oe_n[1] = 1'b1; nxt_sense.out_disable_in1 = pin_sync_ff[1]; end
      pmx_pkg::MD_SEL6: begin nxt_pin_oe_n[1] = 1'b0; nxt_pin_out[1] = i_periph.serial2_transmit; end
      default: ;
    endcase
    unique case (mode[2])
      pmx_pkg::MD_SEL3: begin nxt_pin_oe_n[2] = 1'b1; nxt_sense.ext_interrupt0 = pin_sync_ff[2]; end
      pmx_pkg::MD_SEL5: begin
        nxt_pin_oe_n[2]        = ~i_periph.motor_pwm_oe;
        nxt_pin_out[2]         = i_periph.motor_pwm_out;
        nxt_sense.motor_pwm_in = pin_sync_ff[2];
      end
      pmx_pkg::MD_SEL6: begin
        nxt_pin_oe_n[2]            = ~i_periph.serial2_clock_oe;
        nxt_pin_out[2]             = i_periph.serial2_clock_out;
        nxt_sense.serial2_clock_in = pin_sync_ff[2];
      end
      default: ;
    endcase
    unique case (mode[3])
      pmx_pkg::MD_SEL5: begin nxt_pin_oe_n[3] = 1'b1; nxt_sense.out_disable_in4 = pin_sync_ff[3]; end
      pmx_pkg::MD_SEL6: begin nxt_pin_oe_n[3] = 1'b1; nxt_sense.serial3_receive = pin_sync_ff[3]; end
      default: ;
    endcase
    unique case (mode[9])
      pmx_pkg::MD_SEL1: begin nxt_pin_oe_n[9] = 1'b1; nxt_sense.timer_ext_clock_d = pin_sync_ff[9]; end
      pmx_pkg::MD_SEL2: begin nxt_pin_oe_n[9] = 1'b1; nxt_sense.ext_interrupt3 = pin_sync_ff[9]; end
      pmx_pkg::MD_SEL5: begin nxt_pin_oe_n[9] = 1'b0; nxt_pin_out[9] = i_periph.serial3_transmit; end
      default: ;
    endcase
    unique case (mode[10])
      pmx_pkg::MD_SEL1: begin nxt_pin_oe_n[10] = 1'b0; nxt_pin_out[10] = i_periph.chip_select0; end
      pmx_pkg::MD_SEL2: begin nxt_pin_oe_n[10] = 1'b0; nxt_pin_out[10] = i_periph.read_strobe; end
      pmx_pkg::MD_SEL4: begin nxt_pin_oe_n[10] = 1'b1; nxt_sense.jtag_tck = pin_sync_ff[10]; end
      pmx_pkg::MD_SEL5: begin
        nxt_pin_oe_n[10]           = ~i_periph.serial2_clock_oe;
        nxt_pin_out[10]            = i_periph.serial2_clock_out;
        nxt_sense.serial2_clock_in = nxt_sense.serial2_clock_in | pin_sync_ff[10];
      end
      default: ;
    endcase
    unique case (mode[11])
      pmx_pkg::MD_SEL2: begin nxt_pin_oe_n[11] = 1'b1; nxt_sense.converter_ext_trigger = pin_sync_ff[11]; end
      pmx_pkg::MD_SEL5: begin
        nxt_pin_oe_n[11]           = ~i_periph.serial3_clock_oe;
        nxt_pin_out[11]            = i_periph.serial3_clock_out;
        nxt_sense.serial3_clock_in = pin_sync_ff[11];
      end
      default: ;
    endcase
    unique case (mode[12])
      pmx_pkg::MD_SEL1: begin nxt_pin_oe_n[12] = 1'b0; nxt_pin_out[12] = i_periph.low_byte_write_strobe; end
      pmx_pkg::MD_SEL2: begin nxt_pin_oe_n[12] = 1'b0; nxt_pin_out[12] = i_periph.break_trigger_out; end
      pmx_pkg::MD_SEL4: begin nxt_pin_oe_n[12] = 1'b1; nxt_sense.jtag_tdi = pin_sync_ff[12]; end
      default: ;
    endcase
    unique case (mode[13])
      pmx_pkg::MD_SEL2: begin
        nxt_pin_oe_n[13]          = 1'b1;
        nxt_sense.out_disable_in4 = nxt_sense.out_disable_in4 | pin_sync_ff[13];
      end
      pmx_pkg::MD_SEL4: begin nxt_pin_oe_n[13] = 1'b0; nxt_pin_out[13] = i_periph.jtag_tdo; end
      pmx_pkg::MD_SEL5: begin nxt_pin_oe_n[13] = 1'b1; nxt_sense.bus_request_in = pin_sync_ff[13]; end
      default: ;
    endcase
    unique case (mode[14])
      pmx_pkg::MD_SEL1: begin nxt_pin_oe_n[14] = 1'b0; nxt_pin_out[14] = i_periph.read_strobe; end
      pmx_pkg::MD_SEL2: begin nxt_pin_oe_n[14] = 1'b1; nxt_sense.out_disable_in5 = pin_sync_ff[14]; end
      pmx_pkg::MD_SEL4: begin nxt_pin_oe_n[14] = 1'b1; nxt_sense.jtag_tms = pin_sync_ff[14]; end
      default: ;
    endcase
    unique case (mode[15])
      pmx_pkg::MD_SEL1: begin nxt_pin_oe_n[15] = 1'b0; nxt_pin_out[15] = i_periph.system_clock_out; end
      pmx_pkg::MD_SEL2: begin nxt_pin_oe_n[15] = 1'b1; nxt_sense.out_disable_in6 = pin_sync_ff[15]; end
      pmx_pkg::MD_SEL4: begin nxt_pin_oe_n[15] = 1'b1; nxt_sense.jtag_trst = pin_sync_ff[15]; end
      pmx_pkg::MD_SEL5: begin nxt_pin_oe_n[15] = 1'b0; nxt_pin_out[15] = i_periph.bus_release_ack; end
      default: ;
    endcase
  end

  // The pin outputs lag the selection by one cycle; this keeps every output on a flop.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pin_out_ff  <= '0;
      pin_oe_n_ff <= '1;
      gpio_in_ff  <= '0;
      sense_ff    <= '0;
    end else begin
      pin_out_ff  <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
      gpio_in_ff  <= nxt_gpio_in;
      sense_ff    <= nxt_sense;
    end
  end

  assign o_rdata    = rdata_ff;
  assign o_pin_out  = pin_out_ff;
  assign o_pin_oe_n = pin_oe_n_ff;
  assign o_gpio_in  = gpio_in_ff;
  assign o_periph   = sense_ff;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence seq_write_mid;
    i_wr && i_addr == pmx_pkg::OFF_SEL_MID;
  endsequence
  sequence seq_read_mid;
    i_rd && !i_wr && i_addr == pmx_pkg::OFF_SEL_MID;
  endsequence

  chk_mid_write_readback: assert property (
    seq_write_mid ##1 seq_read_mid |=> o_rdata == ($past(i_wdata, 2) & pmx_pkg::MID_MASK))
    else $error("mid selection register did not read back its write");
  chk_reset_port_mode: assert property (disable iff (1'b0)
    i_reset && dbg_sync_ff |=> sel_high_ff == '0 && sel_mid_ff == '0 && sel_low_ff == '0)
    else $error("selection registers not cleared by reset");
  chk_reset_debug_set: assert property (disable iff (1'b0)
    i_reset && !dbg_sync_ff |=> sel_high_ff == pmx_pkg::HIGH_DBG_SET)
    else $error("debug reset value of high register wrong");
  chk_line3_serial_rx: assert property (
    mode[3] == pmx_pkg::MD_SEL6 |=> o_pin_oe_n[3] && o_periph.serial3_receive == $past(pin_sync_ff[3]))
    else $error("line 3 serial3 receive routing wrong");
  chk_line2_pwm_drive: assert property (
    mode[2] == pmx_pkg::MD_SEL5 && i_periph.motor_pwm_oe
    |=> !o_pin_oe_n[2] && o_pin_out[2] == $past(i_periph.motor_pwm_out))
    else $error("line 2 motor PWM drive wrong");
  chk_line1_serial_tx: assert property (
    mode[1] == pmx_pkg::MD_SEL6 |=> !o_pin_oe_n[1] && o_pin_out[1] == $past(i_periph.serial2_transmit))
    else $error("line 1 serial2 transmit wrong");
  chk_line0_serial_rx: assert property (
    mode[0] == pmx_pkg::MD_SEL6 |=> o_periph.serial2_receive == $past(pin_sync_ff[0]))
    else $error("line 0 serial2 receive wrong");
  chk_line15_clock_out: assert property (
    mode[15] == pmx_pkg::MD_SEL1 |=> !o_pin_oe_n[15] && o_pin_out[15] == $past(i_periph.system_clock_out))
    else $error("line 15 clock output wrong");
  // Debug reset leaves line 14 in test mode, and the release edge still sees reset-forced outputs.
  chk_line14_test_mode: assert property (
    !i_reset && mode[14] == pmx_pkg::MD_SEL4
    |=> o_pin_oe_n[14] && o_periph.jtag_tms == $past(pin_sync_ff[14]))
    else $error("line 14 test mode select wrong");
  chk_line13_bus_req: assert property (
    mode[13] == pmx_pkg::MD_SEL5 |=> o_periph.bus_request_in == $past(pin_sync_ff[13]))
    else $error("line 13 bus request wrong");
  chk_line12_break_out: assert property (
    mode[12] == pmx_pkg::MD_SEL2 |=> !o_pin_oe_n[12] && o_pin_out[12] == $past(i_periph.break_trigger_out))
    else $error("line 12 break trigger wrong");
  chk_line11_conv_trig: assert property (
    mode[11] == pmx_pkg::MD_SEL2 |=> o_periph.converter_ext_trigger == $past(pin_sync_ff[11]))
    else $error("line 11 converter trigger wrong");
  chk_line10_chip_sel: assert property (
    mode[10] == pmx_pkg::MD_SEL1 |=> !o_pin_oe_n[10] && o_pin_out[10] == $past(i_periph.chip_select0))
    else $error("line 10 chip select wrong");
  chk_line9_interrupt: assert property (
    mode[9] == pmx_pkg::MD_SEL2 |=> o_pin_oe_n[9] && o_periph.ext_interrupt3 == $past(pin_sync_ff[9]))
    else $error("line 9 interrupt 3 wrong");
  chk_line1_port_release: assert property (
    mode[1] == pmx_pkg::MD_SEL5 && i_gpio_dir[1] |=> o_pin_oe_n[1])
    else $error("port direction leaked onto a peripheral input line");
  chk_bad_code_port: assert property (
    mode[0] == pmx_pkg::MD_SEL1
    |=> o_pin_oe_n[0] == !$past(i_gpio_dir[0]) && o_pin_out[0] == $past(i_gpio_out[0]))
    else $error("unassigned code did not keep port behaviour");

endmodule // pmx_porta_mux
`default_nettype wire

// [tb/pmx_porta_mux_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pmx_porta_mux_tb;
  localparam int N = 31;
  logic                       i_core_clk;
  logic                       i_reset;
  logic [pmx_pkg::ADDR_W-1:0] i_addr;
  logic [pmx_pkg::DATA_W-1:0] i_wdata;
  logic                       i_wr;
  logic                       i_rd;
  logic [pmx_pkg::DATA_W-1:0] o_rdata;
  logic                       i_debug_mode_n;
  logic [15:0]                i_pin_in;
  logic [15:0]                o_pin_out;
  logic [15:0]                o_pin_oe_n;
  logic [15:0]                i_gpio_out;
  logic [15:0]                i_gpio_dir;
  logic [15:0]                o_gpio_in;
  pmx_pkg::pmx_drive_t        i_periph;
  pmx_pkg::pmx_sense_t        o_periph;
  logic [15:0]                exp_q[$];
  logic                       rd_d;
  logic                       started;
  int                         errors;
  int                         n_tests;
  logic [3:0]                 offs [3] = '{pmx_pkg::OFF_SEL_HIGH, pmx_pkg::OFF_SEL_MID, pmx_pkg::OFF_SEL_LOW};
  logic [15:0]                msks [3] = '{16'hFE0F, 16'h00FF, 16'hFFFC};
  // Each row: line, code, output field, enable field, input field; N marks none.
  // Only the last four rows write unassigned codes, on purpose, to probe the port fallback.
  int                         tbl [36][5] = '{
    '{3, 5, N, N, 16}, '{3, 6, N, N, 12}, '{3, 0, N, N, N},
    '{2, 3, N, N, 9}, '{2, 5, 8, 7, 7}, '{2, 6, 12, 11, 11},
    '{1, 5, N, N, 17}, '{1, 6, 14, N, N},
    '{0, 5, N, N, 18}, '{0, 6, N, N, 13},
    '{15, 1, 6, N, N}, '{15, 2, N, N, 14}, '{15, 4, N, N, 3}, '{15, 5, 5, N, N},
    '{14, 1, 4, N, N}, '{14, 2, N, N, 15}, '{14, 4, N, N, 2},
    '{13, 2, N, N, 16}, '{13, 4, 0, N, N}, '{13, 5, N, N, 4},
    '{12, 1, 3, N, N}, '{12, 2, 1, N, N}, '{12, 4, N, N, 1},
    '{11, 2, N, N, 5}, '{11, 5, 10, 9, 10},
    '{10, 1, 2, N, N}, '{10, 2, 4, N, N}, '{10, 4, N, N, 0}, '{10, 5, 12, 11, 11},
    '{9, 1, N, N, 6}, '{9, 2, N, N, 8}, '{9, 5, 13, N, N},
    '{3, 3, N, N, N}, '{11, 4, N, N, N}, '{9, 7, N, N, N}, '{0, 1, N, N, N}
  };

  pmx_porta_mux dut (
    .i_core_clk     (i_core_clk),
    .i_reset        (i_reset),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .i_debug_mode_n (i_debug_mode_n),
    .i_pin_in       (i_pin_in),
    .o_pin_out      (o_pin_out),
    .o_pin_oe_n     (o_pin_oe_n),
    .i_gpio_out     (i_gpio_out),
    .i_gpio_dir     (i_gpio_dir),
    .o_gpio_in      (o_gpio_in),
    .i_periph       (i_periph),
    .o_periph       (o_periph)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Comparisons: %0d, mismatches: %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read data is only valid in the cycle after the strobe and must be zero otherwise.
  always @(posedge i_core_clk) begin
    if (rd_d) begin
      check("o_rdata", 32'(o_rdata), 32'(exp_q.pop_front()));
    end else if (started && !i_reset) begin
      check("o_rdata idle", 32'(o_rdata), 32'h0);
    end
    rd_d <= i_rd && !i_reset;
  end

  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge i_core_clk);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    if (r) exp_q.push_back(e);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d, 16'h0000);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, 1'b1, a, 16'h0000, e);
  endtask

  task automatic idle();
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask

  // The strap is held for the whole reset so the synchroniser settles before release.
  task automatic do_reset(input logic dbg_n);
    @(posedge i_core_clk);
    i_reset <= 1'b1;
    i_debug_mode_n <= dbg_n;
    repeat (4) @(posedge i_core_clk);
    i_reset <= 1'b0;
  endtask

  task automatic route(input int t);
    int          l;
    int          c;
    int          o;
    int          e;
    int          s;
    logic [15:0] hi;
    logic [15:0] md;
    logic [15:0] lo;
    logic [15:0] xo;
    logic [15:0] xn;
    logic [15:0] msk;
    logic [18:0] xs;
    logic [14:0] r15;
    l = tbl[t][0];
    c = tbl[t][1];
    o = tbl[t][2];
    e = tbl[t][3];
    s = tbl[t][4];
    hi = 16'((c >> 2) & 1) << l;
    md = 16'h0000;
    lo = 16'h0000;
    if (l <= 3) md = 16'(c & 3) << (2 * l);
    else lo = 16'(c & 3) << (2 * l - 16);
    r15 = 15'($urandom);
    i_periph <= pmx_pkg::pmx_drive_t'(r15);
    i_pin_in <= 16'($urandom);
    i_gpio_out <= 16'($urandom);
    i_gpio_dir <= 16'($urandom);
    wr(pmx_pkg::OFF_SEL_HIGH, hi);
    wr(pmx_pkg::OFF_SEL_MID, md);
    wr(pmx_pkg::OFF_SEL_LOW, lo);
    rd(pmx_pkg::OFF_SEL_HIGH, hi);
    rd(pmx_pkg::OFF_SEL_MID, md);
    rd(pmx_pkg::OFF_SEL_LOW, lo);
    idle();
    repeat (5) @(posedge i_core_clk);
    xo = i_gpio_out;
    xn = ~i_gpio_dir;
    msk = 16'hFFFF;
    xs = '0;
    if (o != N) begin
      xo[l] = r15[o];
      xn[l] = (e == N) ? 1'b0 : ~r15[e];
    end else if (s != N) begin
      xn[l] = 1'b1;
      msk[l] = 1'b0;
    end
    if (s != N) xs[s] = i_pin_in[l];
    check("o_pin_out", 32'(o_pin_out & msk), 32'(xo & msk));
    check("o_pin_oe_n", 32'(o_pin_oe_n), 32'(xn));
    check("o_periph", 32'(o_periph), 32'(xs));
    check("o_gpio_in", 32'(o_gpio_in), 32'(i_pin_in));
  endtask

  initial begin
    logic [15:0] w;
    i_reset = 1'b1;
    i_addr = '0;
    i_wdata = '0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_debug_mode_n = 1'b1;
    i_pin_in = '0;
    i_gpio_out = '0;
    i_gpio_dir = '0;
    i_periph = '0;
    rd_d = 1'b0;
    started = 1'b0;
    errors = 0;
    n_tests = 0;
    void'($urandom(32'h36dcfb9e));
    repeat (4) @(posedge i_core_clk);
    i_reset <= 1'b0;
    started <= 1'b1;
    for (int i = 0; i < 3; i++) rd(offs[i], 16'h0000);
    wr(4'hC, 16'hFFFF);
    rd(4'hC, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(offs[i], 16'hFFFF);
      rd(offs[i], msks[i]);
    end
    for (int i = 0; i < 9; i++) begin
      w = 16'($urandom);
      wr(offs[i % 3], w);
      rd(offs[i % 3], w & msks[i % 3]);
    end
    idle();
    // The bench models the flash version, which allows the debug-port and break-trigger codes.
    for (int t = 0; t < 36; t++) route(t);
    do_reset(1'b0);
    rd(pmx_pkg::OFF_SEL_HIGH, 16'hF400);
    rd(pmx_pkg::OFF_SEL_MID, 16'h0000);
    rd(pmx_pkg::OFF_SEL_LOW, 16'h0000);
    idle();
    do_reset(1'b1);
    rd(pmx_pkg::OFF_SEL_HIGH, 16'h0000);
    idle();
    repeat (3) @(posedge i_core_clk);
    summarize();
  end

  // The full run takes well under a thousand cycles, so this limit only catches a hang.
  initial begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    $display("wrong value watchdog: expected finish, seen timeout");
    summarize();
  end
endmodule // pmx_porta_mux_tb
`default_nettype wire
